/* rtl/rx_port_status_monitor.sv */
// Purpose: receive port status, error counting and frame diagnostics
// Assumes: link-side inputs are on clock_i; rx_clk_div_i is a raw pin
// Notes: register port is the back end of the serial control target
`timescale 1ns/1ps
`include "rx_port_status_monitor_consts.svh"

module rx_port_status_monitor import rx_port_status_pkg::*; #(
  parameter int unsigned FREQ_WINDOW_CYC = `FREQ_WINDOW_CYC,
  parameter logic [3:0] FREQ_CLK_DIV = `FREQ_CLK_DIV
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output reg_byte_t reg_rdata_o,
  input wire logic lock_i,
  input wire logic ctrl_crc_err_i,
  input wire logic ctrl_order_err_i,
  input wire logic parity_err_i,
  input wire logic enc_err_i,
  input wire logic [15:0] par_err_thresh_i,
  input wire logic rx_clk_div_i,
  input wire logic info_valid_i,
  input wire logic info_crc_ok_i,
  input wire logic [2:0] info_sel_i,
  input wire logic [7:0] info_data_i,
  input wire logic pkt_mode_i,
  input wire logic frame_start_i,
  input wire logic frame_end_i,
  input wire logic long_pkt_i,
  input wire logic [15:0] pkt_len_i,
  input wire logic line_valid_strobe_i,
  input wire logic byte_valid_i,
  input wire logic line_irq_en_i,
  input wire logic line_count_rd_i,
  input wire logic line_byte_length_rd_i,
  input wire logic sensor_rise_rd_i,
  input wire logic sensor_fall_rd_i,
  output count16_t line_count_o,
  output count16_t line_byte_length_o,
  output logic line_count_irq_o,
  output logic line_byte_length_irq_o,
  output reg_byte_t sensor_rise_irq_status_o,
  output reg_byte_t sensor_fall_irq_status_o,
  output logic sensor_irq_o,
  output logic parity_irq_o,
  output logic enc_err_irq_o,
  output logic freq_change_irq_o
);
  function automatic logic at_ofs(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  logic rst_s1_ff, rst_s2_ff, rst_n;
  reg_byte_t general_config_ff, port_cap_ff, freq_det_ff, enc_crc_ff;
  logic lock_d_ff, lock_chg_ff, crc_flag_ff, order_flag_ff, enc_flag_ff;
  count16_t par_cnt_ff, nxt_par_cnt;
  logic par_flag_ff, nxt_par_flag;
  reg_byte_t par_low_hold_ff;
  count16_t freq_meas_ff, meas;
  logic meas_done, steady_ff, no_clk_ff, freq_chg_ff;
  reg_byte_t prev_mhz_ff, mhz, mhz_diff;
  reg_byte_t dp0_ff, dp1_ff, ser_id_ff;
  logic [31:0] sensor_flat;
  reg_byte_t rise_ff, fall_ff;
  frame_state_t frame_ff;
  count16_t frame_lines_ff, byte_cnt_ff, last_len_ff;
  count16_t nxt_lines, nxt_len;
  logic lv_d_ff, count_frozen_ff, len_frozen_ff;
  logic rd_s1, rd_s2, par_rd, wr_hit, lock_lost, par_clr, par_evt;
  logic info_upd, line_evt, raw_end, frame_close;
  reg_byte_t rd_mux, status_one, status_two;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  assign rst_n = rst_s2_ff;

  assign rd_s1 = reg_rd_i & at_ofs(reg_addr_i, `OFS_STATUS_ONE);
  assign rd_s2 = reg_rd_i & at_ofs(reg_addr_i, `OFS_STATUS_TWO);
  assign par_rd = reg_rd_i & at_ofs(reg_addr_i, `OFS_PAR_HIGH);
  assign wr_hit = reg_wr_i;

  // writable configuration
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      general_config_ff <= `GENERAL_CONFIG_RST;
      port_cap_ff <= `PORT_CAP_RST;
      freq_det_ff <= `FREQUENCY_DETECT_CONTROL_RST;
      enc_crc_ff <= `ENC_CRC_CTL_RST;
    end else if (wr_hit) begin
      if (at_ofs(reg_addr_i, `OFS_GENERAL_CONFIG)) begin
        general_config_ff <= reg_wdata_i;
      end
      if (at_ofs(reg_addr_i, `OFS_PORT_CAP)) begin
        port_cap_ff <= reg_wdata_i;
      end
      if (at_ofs(reg_addr_i, `OFS_FREQUENCY_DETECT_CONTROL)) begin
        freq_det_ff <= reg_wdata_i;
      end
      if (at_ofs(reg_addr_i, `OFS_ENC_CRC_CTL)) begin
        enc_crc_ff <= reg_wdata_i;
      end
    end
  end

  // sticky event flags; a new event beats the read that clears it
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      lock_d_ff <= 1'b0;
      lock_chg_ff <= 1'b0;
      crc_flag_ff <= 1'b0;
      order_flag_ff <= 1'b0;
      enc_flag_ff <= 1'b0;
    end else begin
      lock_d_ff <= lock_i;
      lock_chg_ff <= (lock_i != lock_d_ff) | (lock_chg_ff & ~rd_s1);
      crc_flag_ff <= ctrl_crc_err_i | (crc_flag_ff & ~rd_s1);
      order_flag_ff <= ctrl_order_err_i | (order_flag_ff & ~rd_s1);
      enc_flag_ff <= enc_err_i | (enc_flag_ff & ~rd_s2);
    end
  end
  assign enc_err_irq_o = enc_flag_ff;

  // parity counting; counting stops while checking is disabled
  assign par_evt = parity_err_i & general_config_ff[`GC_PAR_CHECK_EN];
  assign lock_lost = lock_d_ff & ~lock_i;
  assign par_clr = par_rd | (lock_lost & ~general_config_ff[`GC_PAR_KEEP]);

  always_comb begin
    nxt_par_cnt = par_cnt_ff;
    nxt_par_flag = par_flag_ff;
    if (par_clr) begin
      nxt_par_cnt = 16'h0000;
      nxt_par_flag = 1'b0;
    end
    if (par_evt && nxt_par_cnt != 16'hffff) begin
      nxt_par_cnt = nxt_par_cnt + 16'h0001;
    end
    if (par_evt && par_err_thresh_i != 16'h0000 &&
        nxt_par_cnt >= par_err_thresh_i) begin
      nxt_par_flag = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      par_cnt_ff <= 16'h0000;
      par_flag_ff <= 1'b0;
      par_low_hold_ff <= 8'h00;
    end else begin
      par_cnt_ff <= nxt_par_cnt;
      par_flag_ff <= nxt_par_flag;
      // high byte read snaps the low byte so the pair stays coherent
      if (par_rd) begin
        par_low_hold_ff <= par_cnt_ff[7:0];
      end
    end
  end
  assign parity_irq_o = par_flag_ff;

  // input frequency measurement
  rx_freq_meter #(
    .WINDOW_CYC(FREQ_WINDOW_CYC),
    .CLK_DIV(FREQ_CLK_DIV)
  ) u_freq_meter (
    .clock_i(clock_i),
    .rst_b_i(rst_n),
    .rx_clk_div_i(rx_clk_div_i),
    .meas_o(meas),
    .meas_done_o(meas_done)
  );

  assign mhz = meas[15:8];
  assign mhz_diff = (mhz > prev_mhz_ff) ? (mhz - prev_mhz_ff)
                                         : (prev_mhz_ff - mhz);

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      freq_meas_ff <= 16'h0000;
      prev_mhz_ff <= 8'h00;
      steady_ff <= 1'b0;
      no_clk_ff <= 1'b1;
    end else if (meas_done) begin
      freq_meas_ff <= meas;
      prev_mhz_ff <= mhz;
      steady_ff <= (mhz_diff <= {4'h0, freq_det_ff[7:4]});
      no_clk_ff <= (mhz < {4'h0, freq_det_ff[3:0]});
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      freq_chg_ff <= 1'b0;
    end else begin
      freq_chg_ff <= (meas_done && mhz_diff > {4'h0, freq_det_ff[7:4]}) |
                     (freq_chg_ff & ~rd_s2);
    end
  end
  assign freq_change_irq_o = freq_chg_ff;

  // link information; a failed CRC only blocks when checking is enabled
  assign info_upd = info_valid_i &
                    (info_crc_ok_i | enc_crc_ff[`ENC_CRC_DISABLE]);

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      dp0_ff <= 8'h00;
      dp1_ff <= 8'h00;
      ser_id_ff <= 8'h00;
    end else if (info_upd) begin
      if (info_sel_i == `INFO_SEL_DP0) begin
        dp0_ff <= info_data_i;
      end
      if (info_sel_i == `INFO_SEL_DP1) begin
        dp1_ff <= info_data_i;
      end
      if (info_sel_i == `INFO_SEL_SER_ID) begin
        ser_id_ff <= info_data_i;
      end
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_sensor
    reg_byte_t val_ff;
    always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
        val_ff <= 8'h00;
      end else if (info_upd && info_sel_i == 3'(g)) begin
        val_ff <= info_data_i;
      end
    end
    assign sensor_flat[8*g +: 8] = val_ff;
  end

  // edge status tracks sensor byte zero only
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rise_ff <= 8'h00;
      fall_ff <= 8'h00;
    end else begin
      if (info_upd && info_sel_i == 3'h0) begin
        rise_ff <= (info_data_i & ~sensor_flat[7:0]) |
                   (rise_ff & ~{8{sensor_rise_rd_i}});
        fall_ff <= (~info_data_i & sensor_flat[7:0]) |
                   (fall_ff & ~{8{sensor_fall_rd_i}});
      end else begin
        rise_ff <= rise_ff & ~{8{sensor_rise_rd_i}};
        fall_ff <= fall_ff & ~{8{sensor_fall_rd_i}};
      end
    end
  end
  assign sensor_rise_irq_status_o = rise_ff;
  assign sensor_fall_irq_status_o = fall_ff;
  assign sensor_irq_o = (|rise_ff) | (|fall_ff);

  // line and frame tracking
  assign raw_end = ~pkt_mode_i & lv_d_ff & ~line_valid_strobe_i;
  assign line_evt = (pkt_mode_i & long_pkt_i) |
                    (~pkt_mode_i & ~lv_d_ff & line_valid_strobe_i);
  assign frame_close = (frame_ff == FRAME_OPEN) & frame_end_i;
  assign nxt_lines = (frame_ff == FRAME_OPEN && line_evt)
                     ? frame_lines_ff + 16'h0001 : frame_lines_ff;
  assign nxt_len = (pkt_mode_i && long_pkt_i) ? pkt_len_i
                   : (raw_end ? byte_cnt_ff : last_len_ff);

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      frame_ff <= FRAME_IDLE;
    end else begin
      case (frame_ff)
        FRAME_IDLE: begin
          if (frame_start_i) begin
            frame_ff <= FRAME_OPEN;
          end
        end
        FRAME_OPEN: begin
          if (frame_end_i) begin
            frame_ff <= FRAME_IDLE;
          end
        end
        default: begin
          frame_ff <= FRAME_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      lv_d_ff <= 1'b0;
      frame_lines_ff <= 16'h0000;
      byte_cnt_ff <= 16'h0000;
      last_len_ff <= 16'h0000;
    end else begin
      lv_d_ff <= line_valid_strobe_i;
      frame_lines_ff <= frame_start_i ? 16'h0000 : nxt_lines;
      if (~pkt_mode_i & ~lv_d_ff & line_valid_strobe_i) begin
        byte_cnt_ff <= {15'h0000, byte_valid_i};
      end else if (line_valid_strobe_i && byte_valid_i) begin
        byte_cnt_ff <= byte_cnt_ff + 16'h0001;
      end
      last_len_ff <= nxt_len;
    end
  end

  // published values hold while their change interrupt waits for a read
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      line_count_o <= 16'h0000;
      count_frozen_ff <= 1'b0;
    end else begin
      if (frame_close && !(line_irq_en_i && count_frozen_ff)) begin
        line_count_o <= nxt_lines;
      end
      if (frame_close && line_irq_en_i && !count_frozen_ff &&
          nxt_lines != line_count_o) begin
        count_frozen_ff <= 1'b1;
      end else if (line_count_rd_i || !line_irq_en_i) begin
        count_frozen_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      line_byte_length_o <= 16'h0000;
      len_frozen_ff <= 1'b0;
    end else begin
      if (frame_close && !(line_irq_en_i && len_frozen_ff)) begin
        line_byte_length_o <= nxt_len;
      end
      if (frame_close && line_irq_en_i && !len_frozen_ff &&
          nxt_len != line_byte_length_o) begin
        len_frozen_ff <= 1'b1;
      end else if (line_byte_length_rd_i || !line_irq_en_i) begin
        len_frozen_ff <= 1'b0;
      end
    end
  end
  assign line_count_irq_o = count_frozen_ff;
  assign line_byte_length_irq_o = len_frozen_ff;

  // register read path
  always_comb begin
    status_one = 8'h00;
    status_one[`S1_LOCK] = lock_i;
    status_one[`S1_PARITY] = par_flag_ff;
    status_one[`S1_CRC] = crc_flag_ff;
    status_one[`S1_ORDER] = order_flag_ff;
    status_one[`S1_LOCK_CHG] = lock_chg_ff;
    status_two = 8'h00;
    status_two[`S2_NO_CLK] = no_clk_ff;
    status_two[`S2_STEADY] = steady_ff;
    status_two[`S2_FREQ_CHG] = freq_chg_ff;
    status_two[`S2_ENC_ERR] = enc_flag_ff;
  end

  always_comb begin
    case (reg_addr_i)
      `OFS_GENERAL_CONFIG: rd_mux = general_config_ff;
      `OFS_PORT_CAP: rd_mux = port_cap_ff;
      `OFS_STATUS_ONE: rd_mux = status_one;
      `OFS_STATUS_TWO: rd_mux = status_two;
      `OFS_FREQ_HIGH: rd_mux = freq_meas_ff[15:8];
      `OFS_FREQ_LOW: rd_mux = freq_meas_ff[7:0];
      `OFS_SENSOR_0: rd_mux = sensor_flat[7:0];
      `OFS_SENSOR_1: rd_mux = sensor_flat[15:8];
      `OFS_SENSOR_2: rd_mux = sensor_flat[23:16];
      `OFS_SENSOR_3: rd_mux = sensor_flat[31:24];
      `OFS_PAR_HIGH: rd_mux = par_cnt_ff[15:8];
      `OFS_PAR_LOW: rd_mux = par_low_hold_ff;
      `OFS_DATAPATH_0: rd_mux = dp0_ff;
      `OFS_DATAPATH_1: rd_mux = dp1_ff;
      `OFS_SER_ID: rd_mux = ser_id_ff;
      `OFS_FREQUENCY_DETECT_CONTROL: rd_mux = freq_det_ff;
      `OFS_ENC_CRC_CTL: rd_mux = enc_crc_ff;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end
  end
endmodule // rx_port_status_monitor

/* inc/rx_port_status_monitor_consts.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 8-bit register space, 40 MHz core clock
// Notes: definitions only
`ifndef RX_PORT_STATUS_MONITOR_CONSTS_SVH
`define RX_PORT_STATUS_MONITOR_CONSTS_SVH

`define OFS_GENERAL_CONFIG 8'h02
`define OFS_PORT_CAP 8'h4a
`define OFS_STATUS_ONE 8'h4d
`define OFS_STATUS_TWO 8'h4e
`define OFS_FREQ_HIGH 8'h4f
`define OFS_FREQ_LOW 8'h50
`define OFS_SENSOR_0 8'h51
`define OFS_SENSOR_1 8'h52
`define OFS_SENSOR_2 8'h53
`define OFS_SENSOR_3 8'h54
`define OFS_PAR_HIGH 8'h55
`define OFS_PAR_LOW 8'h56
`define OFS_DATAPATH_0 8'h59
`define OFS_DATAPATH_1 8'h5a
`define OFS_SER_ID 8'h5b
`define OFS_FREQUENCY_DETECT_CONTROL 8'h77
`define OFS_ENC_CRC_CTL 8'hba

`define GC_PAR_KEEP 0
`define GC_PAR_CHECK_EN 1
`define CAP_CRC_CAPABLE 4
`define ENC_CRC_DISABLE 7
`define S1_LOCK 0
`define S1_PARITY 1
`define S1_CRC 2
`define S1_ORDER 3
`define S1_LOCK_CHG 4
`define S2_NO_CLK 1
`define S2_STEADY 2
`define S2_FREQ_CHG 3
`define S2_ENC_ERR 5

`define GENERAL_CONFIG_RST 8'h02
`define PORT_CAP_RST 8'h00
`define FREQUENCY_DETECT_CONTROL_RST 8'h21
`define ENC_CRC_CTL_RST 8'h80

`define INFO_SEL_DP0 3'h4
`define INFO_SEL_DP1 3'h5
`define INFO_SEL_SER_ID 3'h6

`define CLK_MHZ 40
`define FREQ_WINDOW_US 256
`define FREQ_WINDOW_CYC (`FREQ_WINDOW_US * `CLK_MHZ)
`define FREQ_CLK_DIV 4'h8

`endif

/* inc/rx_port_status_pkg.sv */
// Purpose: shared types of the port status monitor
// Assumes: nothing
// Notes: constants live in the consts header
package rx_port_status_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [15:0] count16_t;
  typedef enum logic [0:0] {
    FRAME_IDLE = 1'b0,
    FRAME_OPEN = 1'b1
  } frame_state_t;
endpackage

/* rtl/rx_freq_meter.sv */
// Purpose: measure a divided link input clock in 1/256 MHz units
// Assumes: divided clock well below half the core clock rate
// Notes: pin passes two flip-flops before the edge detector
`timescale 1ns/1ps
`include "rx_port_status_monitor_consts.svh"

module rx_freq_meter import rx_port_status_pkg::*; #(
  parameter int unsigned WINDOW_CYC = `FREQ_WINDOW_CYC,
  parameter logic [3:0] CLK_DIV = `FREQ_CLK_DIV
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic rx_clk_div_i,
  output count16_t meas_o,
  output logic meas_done_o
);
  logic sync1_ff, sync2_ff, sync3_ff;
  count16_t win_ff, edges_ff;
  logic win_end, rise;

  assign win_end = (win_ff == 16'(WINDOW_CYC - 1));
  // third stage only feeds the edge detector, the first is never looked at
  assign rise = sync2_ff & ~sync3_ff;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
    end else begin
      sync1_ff <= rx_clk_div_i;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      win_ff <= 16'h0000;
      edges_ff <= 16'h0000;
      meas_o <= 16'h0000;
      meas_done_o <= 1'b0;
    end else begin
      meas_done_o <= win_end;
      if (win_end) begin
        win_ff <= 16'h0000;
        edges_ff <= {15'h0000, rise};
        meas_o <= 16'(edges_ff * CLK_DIV);
      end else begin
        win_ff <= win_ff + 16'h0001;
        if (rise && edges_ff != 16'hffff) begin
          edges_ff <= edges_ff + 16'h0001;
        end
      end
    end
  end
endmodule // rx_freq_meter

/* verif/rx_port_status_monitor_asserts.sv */
// Purpose: port-level checks of the receive port status monitor
// Assumes: one clock domain, reset active low
// Notes: bound to every instance of the top module
`timescale 1ns/1ps
module rx_port_status_monitor_asserts import rx_port_status_pkg::*; (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire reg_byte_t reg_rdata_o,
  input wire logic lock_i,
  input wire logic parity_err_i,
  input wire logic enc_err_i,
  input wire logic info_valid_i,
  input wire logic line_count_rd_i,
  input wire logic line_byte_length_rd_i,
  input wire logic sensor_rise_rd_i,
  input wire count16_t line_count_o,
  input wire count16_t line_byte_length_o,
  input wire logic line_count_irq_o,
  input wire logic line_byte_length_irq_o,
  input wire reg_byte_t sensor_rise_irq_status_o,
  input wire logic parity_irq_o,
  input wire logic enc_err_irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  sequence par_read_s;
    reg_rd_i && reg_addr_i == 8'h55 && !parity_err_i;
  endsequence
  sequence enc_read_s;
    reg_rd_i && reg_addr_i == 8'h4e && !enc_err_i;
  endsequence
  // the change flag is set one cycle after the change; the two quiet cycles keep reads from clearing it first
  sequence lock_read_s;
    $changed(lock_i) ##1 !reg_rd_i ##1 !reg_rd_i
      ##1 (reg_rd_i && reg_addr_i == 8'h4d);
  endsequence
  rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  unmapped_read_a: assert property (reg_rd_i && reg_addr_i == 8'h10
    |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  lock_change_a: assert property (lock_read_s |=> reg_rdata_o[4])
    else $error("lock change not flagged");
  enc_set_a: assert property (enc_err_i |=> enc_err_irq_o)
    else $error("encoder flag not set");
  enc_clear_a: assert property (enc_read_s |=> !enc_err_irq_o)
    else $error("encoder flag not cleared");
  parity_clear_a: assert property (par_read_s |=> !parity_irq_o)
    else $error("parity flag not cleared by counter read");
  parity_hold_a: assert property (parity_irq_o && lock_i && !reg_rd_i
    |=> parity_irq_o) else $error("parity flag dropped");
  count_freeze_a: assert property (line_count_irq_o && !line_count_rd_i
    |=> line_count_irq_o && $stable(line_count_o))
    else $error("line count not held");
  len_freeze_a: assert property (line_byte_length_irq_o && !line_byte_length_rd_i
    |=> line_byte_length_irq_o && $stable(line_byte_length_o))
    else $error("line length not held");
  rise_clear_a: assert property (sensor_rise_rd_i && !info_valid_i
    |=> sensor_rise_irq_status_o == 8'h00)
    else $error("rise status not cleared");
endmodule // rx_port_status_monitor_asserts

bind rx_port_status_monitor rx_port_status_monitor_asserts chk_u (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .lock_i(lock_i),
  .parity_err_i(parity_err_i), .enc_err_i(enc_err_i),
  .info_valid_i(info_valid_i), .line_count_rd_i(line_count_rd_i),
  .line_byte_length_rd_i(line_byte_length_rd_i), .sensor_rise_rd_i(sensor_rise_rd_i),
  .line_count_o(line_count_o), .line_byte_length_o(line_byte_length_o),
  .line_count_irq_o(line_count_irq_o), .line_byte_length_irq_o(line_byte_length_irq_o),
  .sensor_rise_irq_status_o(sensor_rise_irq_status_o),
  .parity_irq_o(parity_irq_o), .enc_err_irq_o(enc_err_irq_o));

/* verif/rx_serializer_model.sv */
// Purpose: far-side serializer, source of the divided link clock
// Assumes: half period a multiple of the core period
// Notes: clock stands low while not running, as a dead link would
`timescale 1ns/1ps
module rx_serializer_model #(
  parameter real HALF_NS = 100.0
) (
  input wire logic run_i,
  output logic rx_clk_div_o
);
  initial rx_clk_div_o = 1'b0;
  // edges land on core falling edges so the count per window is exact
  always begin
    #(HALF_NS);
    rx_clk_div_o = run_i ? ~rx_clk_div_o : 1'b0;
  end
endmodule // rx_serializer_model

/* verif/rx_port_status_monitor_bench.sv */
// Purpose: self-checking bench of the receive port status monitor
// Assumes: frequency window shortened to 64 core cycles
// Notes: inputs move on falling edges only
`timescale 1ns/1ps
module rx_port_status_monitor_bench;
  typedef struct packed {logic w; logic [7:0] a, d, e;} row_t;
  row_t rows [11] = '{'{1'b0, 8'h4e, 8'h00, 8'h02},
    '{1'b0, 8'h02, 8'h00, 8'h02}, '{1'b0, 8'h4a, 8'h00, 8'h00},
    '{1'b0, 8'h77, 8'h00, 8'h21}, '{1'b0, 8'hba, 8'h00, 8'h80},
    '{1'b0, 8'h4d, 8'h00, 8'h00}, '{1'b0, 8'h55, 8'h00, 8'h00},
    '{1'b0, 8'h10, 8'h00, 8'h00}, '{1'b1, 8'h4a, 8'h10, 8'h10},
    '{1'b1, 8'h4f, 8'hff, 8'h00}, '{1'b1, 8'h10, 8'hff, 8'h00}};
  logic clock_i = 0, rst_b_i = 0, reg_wr_i = 0, reg_rd_i = 0, lock_i = 0;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, info_data_i = 0;
  logic ctrl_crc_err_i = 0, ctrl_order_err_i = 0, parity_err_i = 0;
  logic enc_err_i = 0, info_valid_i = 0, info_crc_ok_i = 0, run = 0;
  logic [15:0] par_err_thresh_i = 0, pkt_len_i = 0;
  logic [2:0] info_sel_i = 0;
  logic pkt_mode_i = 0, frame_start_i = 0, frame_end_i = 0, long_pkt_i = 0;
  logic line_valid_strobe_i = 0, byte_valid_i = 0, line_irq_en_i = 0;
  logic line_count_rd_i = 0, line_byte_length_rd_i = 0, rx_clk_div_i;
  logic sensor_rise_rd_i = 0, sensor_fall_rd_i = 0;
  logic [7:0] reg_rdata_o, rise_o, fall_o;
  logic [15:0] cnt_o, len_o;
  logic cnt_irq_o, len_irq_o, sen_irq_o, par_irq_o, enc_irq_o, frq_irq_o;
  int err_count = 0, n_tests = 0;
  initial forever #12.5 clock_i = ~clock_i;
  rx_serializer_model far_u (.run_i(run), .rx_clk_div_o(rx_clk_div_i));
  rx_port_status_monitor #(.FREQ_WINDOW_CYC(64)) DUT (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .lock_i(lock_i),
    .ctrl_crc_err_i(ctrl_crc_err_i), .ctrl_order_err_i(ctrl_order_err_i),
    .parity_err_i(parity_err_i), .enc_err_i(enc_err_i),
    .par_err_thresh_i(par_err_thresh_i), .rx_clk_div_i(rx_clk_div_i),
    .info_valid_i(info_valid_i), .info_crc_ok_i(info_crc_ok_i),
    .info_sel_i(info_sel_i), .info_data_i(info_data_i),
    .pkt_mode_i(pkt_mode_i), .frame_start_i(frame_start_i),
    .frame_end_i(frame_end_i), .long_pkt_i(long_pkt_i),
    .pkt_len_i(pkt_len_i), .line_valid_strobe_i(line_valid_strobe_i),
    .byte_valid_i(byte_valid_i), .line_irq_en_i(line_irq_en_i),
    .line_count_rd_i(line_count_rd_i), .line_byte_length_rd_i(line_byte_length_rd_i),
    .sensor_rise_rd_i(sensor_rise_rd_i), .sensor_fall_rd_i(sensor_fall_rd_i),
    .line_count_o(cnt_o), .line_byte_length_o(len_o),
    .line_count_irq_o(cnt_irq_o), .line_byte_length_irq_o(len_irq_o),
    .sensor_rise_irq_status_o(rise_o), .sensor_fall_irq_status_o(fall_o),
    .sensor_irq_o(sen_irq_o), .parity_irq_o(par_irq_o),
    .enc_err_irq_o(enc_irq_o), .freq_change_irq_o(frq_irq_o));
  task tick(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i) {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
    @(negedge clock_i) reg_wr_i = 1'b0;
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock_i) {reg_addr_i, reg_rd_i} = {a, 1'b1};
    @(negedge clock_i) reg_rd_i = 1'b0;
    chk(reg_rdata_o, e);
  endtask
  task info(input logic [2:0] s, input logic [7:0] d, input logic ok);
    @(negedge clock_i) {info_sel_i, info_data_i, info_crc_ok_i} = {s, d, ok};
    info_valid_i = 1'b1;
    @(negedge clock_i) info_valid_i = 1'b0;
  endtask
  task raw_line(input int n);
    @(negedge clock_i) {line_valid_strobe_i, byte_valid_i} = 2'b11;
    tick(n);
    {line_valid_strobe_i, byte_valid_i} = 2'b00;
  endtask
  task pkt(input logic [15:0] n);
    @(negedge clock_i) {long_pkt_i, pkt_len_i} = {1'b1, n};
    @(negedge clock_i) long_pkt_i = 1'b0;
  endtask
  task edge_frame(input bit fin);
    @(negedge clock_i) if (fin) frame_end_i = 1'b1; else frame_start_i = 1'b1;
    @(negedge clock_i) {frame_end_i, frame_start_i} = 2'b00;
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #2_000_000;
    err_count++;
    wrap_up;
  end
  initial begin
    tick(4);
    rst_b_i = 1'b1;
    tick(3);
    foreach (rows[k]) begin
      if (rows[k].w) wr(rows[k].a, rows[k].d);
      rdchk(rows[k].a, rows[k].e);
    end
    lock_i = 1'b1;
    tick(2);
    rdchk(8'h4d, 8'h11);
    rdchk(8'h4d, 8'h01);
    @(negedge clock_i) {ctrl_crc_err_i, ctrl_order_err_i} = 2'b11;
    @(negedge clock_i) {ctrl_crc_err_i, ctrl_order_err_i} = 2'b00;
    rdchk(8'h4d, 8'h0d);
    rdchk(8'h4d, 8'h01);
    par_err_thresh_i = 16'h0003;
    repeat (2) begin
      @(negedge clock_i) parity_err_i = 1'b1;
      @(negedge clock_i) parity_err_i = 1'b0;
    end
    chk(par_irq_o, 1'b0);
    @(negedge clock_i) parity_err_i = 1'b1;
    @(negedge clock_i) parity_err_i = 1'b0;
    chk(par_irq_o, 1'b1);
    rdchk(8'h4d, 8'h03);
    wr(8'h02, 8'h00);
    rdchk(8'h55, 8'h00);
    rdchk(8'h56, 8'h03);
    chk(par_irq_o, 1'b0);
    wr(8'h02, 8'h02);
    repeat (2) begin
      @(negedge clock_i) parity_err_i = 1'b1;
      @(negedge clock_i) parity_err_i = 1'b0;
    end
    lock_i = 1'b0;
    tick(2);
    lock_i = 1'b1;
    rdchk(8'h55, 8'h00);
    rdchk(8'h56, 8'h00);
    wr(8'h02, 8'h03);
    @(negedge clock_i) parity_err_i = 1'b1;
    @(negedge clock_i) {parity_err_i, lock_i} = 2'b00;
    tick(2);
    lock_i = 1'b1;
    rdchk(8'h55, 8'h00);
    rdchk(8'h56, 8'h01);
    par_err_thresh_i = 16'h0000;
    @(negedge clock_i) parity_err_i = 1'b1;
    tick(65540);
    parity_err_i = 1'b0;
    wr(8'h02, 8'h00);
    rdchk(8'h55, 8'hff);
    rdchk(8'h56, 8'hff);
    @(negedge clock_i) enc_err_i = 1'b1;
    @(negedge clock_i) enc_err_i = 1'b0;
    chk(enc_irq_o, 1'b1);
    rdchk(8'h4e, 8'h26);
    rdchk(8'h4e, 8'h06);
    for (logic [7:0] i = 8'h04; i < 8'h07; i++) begin
      info(i[2:0], 8'h30 + i, 1'b0);
      rdchk(8'h55 + i, 8'h30 + i);
    end
    wr(8'hba, 8'h00);
    for (logic [7:0] i = 8'h04; i < 8'h07; i++) begin
      info(i[2:0], 8'hc0 + i, 1'b0);
      rdchk(8'h55 + i, 8'h30 + i);
      info(i[2:0], 8'h60 + i, 1'b1);
      rdchk(8'h55 + i, 8'h60 + i);
    end
    info(3'h0, 8'h01, 1'b1);
    chk({sen_irq_o, rise_o}, 9'h101);
    rdchk(8'h51, 8'h01);
    @(negedge clock_i) sensor_rise_rd_i = 1'b1;
    @(negedge clock_i) sensor_rise_rd_i = 1'b0;
    info(3'h0, 8'h00, 1'b1);
    chk({rise_o, fall_o}, 16'h0001);
    @(negedge clock_i) sensor_fall_rd_i = 1'b1;
    @(negedge clock_i) sensor_fall_rd_i = 1'b0;
    chk(sen_irq_o, 1'b0);
    edge_frame(1'b0);
    raw_line(4);
    raw_line(6);
    raw_line(5);
    edge_frame(1'b1);
    tick(1);
    chk(cnt_o, 16'h0003);
    chk(len_o, 16'h0005);
    {pkt_mode_i, line_irq_en_i} = 2'b11;
    edge_frame(1'b0);
    pkt(16'h0100);
    pkt(16'h0040);
    edge_frame(1'b1);
    tick(1);
    chk({cnt_irq_o, len_irq_o, cnt_o}, 18'h30002);
    chk(len_o, 16'h0040);
    edge_frame(1'b0);
    repeat (3) pkt(16'h0080);
    edge_frame(1'b1);
    tick(1);
    chk({cnt_o, len_o}, 32'h00020040);
    @(negedge clock_i) {line_count_rd_i, line_byte_length_rd_i} = 2'b11;
    @(negedge clock_i) {line_count_rd_i, line_byte_length_rd_i} = 2'b00;
    chk({cnt_irq_o, len_irq_o}, 2'b00);
    run = 1'b1;
    wr(8'h77, 8'h20);
    tick(200);
    rdchk(8'h4e, 8'h04);
    rdchk(8'h4f, 8'h00);
    rdchk(8'h50, 8'h40);
    wr(8'h77, 8'h21);
    tick(200);
    rdchk(8'h4e, 8'h06);
    chk(frq_irq_o, 1'b0);
    wrap_up;
  end
endmodule // rx_port_status_monitor_bench
